// ---- pkg/cid_host_params.svh ----
// Constants for the caller-identity receiver sequencer: register map, field
// positions, reset values and timing figures. Definitions only.
`ifndef CID_HOST_PARAMS_SVH
`define CID_HOST_PARAMS_SVH

// Register byte offsets on APB
`define CID_CTRL_OFS        12'h000
`define CID_STATUS_OFS      12'h004
`define CID_INT_STATUS_OFS  12'h008
`define CID_INT_MASK_OFS    12'h00c

// Control register fields
`define CID_CTRL_ENABLE     0
`define CID_CTRL_ADSI       1
`define CID_CTRL_DEMOD_ON   2
`define CID_CTRL_PD_RING    3
`define CID_CTRL_CAS_EN     4
`define CID_CTRL_ABORT      5
`define CID_CTRL_RST        6'h11

// Event bits, same layout in status and mask
`define CID_INT_DONE        0
`define CID_INT_CD_TO       1
`define CID_INT_TONE        2
`define CID_INT_NO_FSK      3
`define CID_INT_W           4
`define CID_INT_MASK_RST    4'h0

// Status register fields
`define CID_ST_STATE_LSB    0
`define CID_ST_CD_N         4
`define CID_ST_TONE         5
`define CID_ST_PD           6
`define CID_ST_DEMOD        7
`define CID_ST_MUTE         8

// Acknowledgement digit codes for the DTMF sender
`define CID_ACK_DTMF_D      4'hd
`define CID_ACK_DTMF_A      4'ha

// Timing
`define CID_CLK_MHZ         250
`define CID_CD_WAIT_MS      3000
`define CID_NO_FSK_MS       500

`endif

// ---- pkg/cid_host_pkg.sv ----
// Types shared by the receiver sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package cid_host_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RING,
		ST_ONH_WAIT_CD,
		ST_ONH_DATA,
		ST_OFF_LISTEN,
		ST_OFF_TONE,
		ST_OFF_ACK,
		ST_OFF_ACK_WAIT,
		ST_OFF_WAIT_CD,
		ST_OFF_DATA
	} seq_state_t;
endpackage

// ---- logic/sync_stage.sv ----
// Two-flop synchroniser, one chain per bit.
// Assumes asynchronous inputs and a single clock pclk.
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
	parameter int               WIDTH   = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             pclk,     // System clock
	input  wire logic             presetn,  // Async reset, active low
	input  wire logic [WIDTH-1:0] async_in, // Unsynchronised levels
	output logic      [WIDTH-1:0] sync_out  // Synchronised levels
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic meta_reg;
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					meta_reg    <= RST_VAL[i];
					sync_out[i] <= RST_VAL[i];
				end
				else
				begin
					meta_reg    <= async_in[i];
					sync_out[i] <= meta_reg;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ---- logic/cid_host_ctrl.sv ----
// Sequencer that drives a caller-identity receiver from outside: power-down,
// demodulator enable, acknowledgement request, handset mute; APB registers.
// Assumes a DTMF sender that takes ack_start/ack_digit and answers ack_done,
// and synchronous ring_active/off_hook levels from the line interface.
`timescale 1ns/1ps
`default_nettype none
`include "cid_host_params.svh"
module cid_host_ctrl
	import cid_host_pkg::*;
#(
	parameter int unsigned CD_WAIT_CYC = `CID_CD_WAIT_MS * 1000 * `CID_CLK_MHZ,
	parameter int unsigned NO_FSK_CYC  = `CID_NO_FSK_MS * 1000 * `CID_CLK_MHZ
) (
	input  wire logic        pclk,              // 250 MHz clock
	input  wire logic        presetn,           // Async reset, active low
	input  wire logic        psel,              // APB select
	input  wire logic        penable,           // APB enable
	input  wire logic        pwrite,            // APB direction
	input  wire logic [11:0] paddr,             // APB byte address
	input  wire logic [31:0] pwdata,            // APB write data
	output logic      [31:0] prdata,            // APB read data
	output logic             pready,            // APB ready
	output logic             pslverr,           // APB error, unmapped
	output logic             irq,               // Level interrupt
	input  wire logic        ring_active,       // Ring envelope present
	input  wire logic        off_hook,          // Equipment off-hook
	input  wire logic        carrier_present_n, // Receiver carrier, active low
	input  wire logic        tone_detect_flag,  // Receiver alert tone present
	output logic             power_down_in,     // Receiver power-down
	output logic             demod_enable,      // Receiver demodulator enable
	output logic             cas_detect_enable, // Alert-tone path switch
	output logic             ack_start,         // One-cycle ack request
	output logic      [3:0]  ack_digit,         // DTMF digit to send
	input  wire logic        ack_done,          // Ack tone finished, pulse
	output logic             handset_mute,      // Handset muted
	output logic             keypad_disable     // Keypad locked
);
	seq_state_t              state_reg;
	logic [5:0]              ctrl_reg;
	logic [`CID_INT_W-1:0]   int_status_reg;
	logic [`CID_INT_W-1:0]   int_mask_reg;
	logic [`CID_INT_W-1:0]   int_set;
	logic [31:0]             timer_reg;
	logic                    cd_n_s;
	logic                    tone_s;
	logic                    tone_s_d_reg;
	logic                    wr_en;
	logic                    timer_hit;
	logic                    abort_pulse;
	logic [31:0]             status_word;

	// Both receiver flags cross from the analogue device's own timing
	sync_stage #(
		.WIDTH   (2),
		.RST_VAL (2'b01)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({tone_detect_flag, carrier_present_n}),
		.sync_out ({tone_s, cd_n_s})
	);

	// APB slave: pready answers in the first access cycle
	assign wr_en = psel && penable && pready && pwrite && !pslverr;

	always_comb
	begin
		status_word = 32'h0;
		status_word[`CID_ST_STATE_LSB +: 4] = state_reg;
		status_word[`CID_ST_CD_N]  = cd_n_s;
		status_word[`CID_ST_TONE]  = tone_s;
		status_word[`CID_ST_PD]    = power_down_in;
		status_word[`CID_ST_DEMOD] = demod_enable;
		status_word[`CID_ST_MUTE]  = handset_mute;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable)
			begin
				case (paddr)
					`CID_CTRL_OFS:       prdata <= {26'h0, ctrl_reg};
					`CID_STATUS_OFS:     prdata <= status_word;
					`CID_INT_STATUS_OFS: prdata <= {28'h0, int_status_reg};
					`CID_INT_MASK_OFS:   prdata <= {28'h0, int_mask_reg};
					default:
					begin
						prdata  <= 32'h0;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// Abort bit is self-clearing so software needs no second write
	assign abort_pulse = ctrl_reg[`CID_CTRL_ABORT];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg     <= `CID_CTRL_RST;
			int_mask_reg <= `CID_INT_MASK_RST;
		end
		else
		begin
			ctrl_reg[`CID_CTRL_ABORT] <= 1'b0;
			if (wr_en && paddr == `CID_CTRL_OFS)
				ctrl_reg <= pwdata[5:0];
			if (wr_en && paddr == `CID_INT_MASK_OFS)
				int_mask_reg <= pwdata[`CID_INT_W-1:0];
		end
	end

	// A new event wins over a write-one-to-clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_status_reg <= '0;
			irq            <= 1'b0;
		end
		else
		begin
			if (wr_en && paddr == `CID_INT_STATUS_OFS)
				int_status_reg <= (int_status_reg & ~pwdata[`CID_INT_W-1:0]) | int_set;
			else
				int_status_reg <= int_status_reg | int_set;
			irq <= |((int_status_reg | int_set) & int_mask_reg);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cas_detect_enable <= 1'b0;
		else
			cas_detect_enable <= ctrl_reg[`CID_CTRL_CAS_EN];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tone_s_d_reg <= 1'b0;
		else
			tone_s_d_reg <= tone_s;
	end

	// One shared wait timer; only the carrier-wait states count
	assign timer_hit = (state_reg == ST_ONH_WAIT_CD) ? (timer_reg >= CD_WAIT_CYC - 1)
	                                                 : (timer_reg >= NO_FSK_CYC - 1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_reg <= 32'h0;
		else if (state_reg == ST_ONH_WAIT_CD || state_reg == ST_OFF_WAIT_CD)
			timer_reg <= timer_reg + 32'h1;
		else
			timer_reg <= 32'h0;
	end

	always_comb
	begin
		int_set = '0;
		int_set[`CID_INT_TONE] = (state_reg == ST_OFF_LISTEN) && tone_s && !tone_s_d_reg;
		int_set[`CID_INT_DONE] = (state_reg == ST_ONH_DATA || state_reg == ST_OFF_DATA) && cd_n_s;
		int_set[`CID_INT_CD_TO]  = (state_reg == ST_ONH_WAIT_CD) && cd_n_s && timer_hit;
		int_set[`CID_INT_NO_FSK] = (state_reg == ST_OFF_WAIT_CD) && cd_n_s && timer_hit;
	end

	// Sequencer; receiver pins change on the same edge as the state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg      <= ST_IDLE;
			power_down_in  <= 1'b1;
			demod_enable   <= 1'b0;
			ack_start      <= 1'b0;
			ack_digit      <= `CID_ACK_DTMF_D;
			handset_mute   <= 1'b0;
			keypad_disable <= 1'b0;
		end
		else
		begin
			ack_start <= 1'b0;
			if (abort_pulse || !ctrl_reg[`CID_CTRL_ENABLE])
			begin
				state_reg      <= ST_IDLE;
				power_down_in  <= 1'b1;
				demod_enable   <= 1'b0;
				handset_mute   <= 1'b0;
				keypad_disable <= 1'b0;
			end
			else
			begin
				case (state_reg)
					ST_IDLE:
					begin
						power_down_in <= 1'b1;
						demod_enable  <= 1'b0;
						if (!off_hook && ring_active)
						begin
							// On-hook reception after ringing, same receiver steps
							state_reg     <= ST_RING;
							power_down_in <= ctrl_reg[`CID_CTRL_PD_RING];
							demod_enable  <= ctrl_reg[`CID_CTRL_DEMOD_ON];
						end
						else if (off_hook && ctrl_reg[`CID_CTRL_CAS_EN])
						begin
							state_reg     <= ST_OFF_LISTEN;
							power_down_in <= 1'b0;
						end
					end
					ST_RING:
					begin
						// Carrier detect is not raised by ringing, so only end of ring or going off-hook matters
						if (off_hook)
						begin
							state_reg     <= ST_IDLE;
							power_down_in <= 1'b1;
							demod_enable  <= 1'b0;
						end
						else if (!ring_active)
						begin
							state_reg     <= ST_ONH_WAIT_CD;
							power_down_in <= 1'b0;
							demod_enable  <= 1'b1;
						end
						else
						begin
							// Software may change the ring policy while ringing goes on
							power_down_in <= ctrl_reg[`CID_CTRL_PD_RING];
							demod_enable  <= ctrl_reg[`CID_CTRL_DEMOD_ON];
						end
					end
					ST_ONH_WAIT_CD:
					begin
						if (!cd_n_s)
							state_reg <= ST_ONH_DATA;
						else if (timer_hit)
						begin
							state_reg     <= ST_IDLE;
							power_down_in <= 1'b1;
							demod_enable  <= 1'b0;
						end
					end
					ST_ONH_DATA:
					begin
						if (cd_n_s)
						begin
							state_reg     <= ST_IDLE;
							power_down_in <= 1'b1;
							demod_enable  <= 1'b0;
						end
					end
					ST_OFF_LISTEN:
					begin
						if (!off_hook || !ctrl_reg[`CID_CTRL_CAS_EN])
						begin
							state_reg     <= ST_IDLE;
							power_down_in <= 1'b1;
						end
						else if (tone_s && !tone_s_d_reg)
						begin
							// Flag already includes the receiver's guard timing
							state_reg      <= ST_OFF_TONE;
							handset_mute   <= 1'b1;
							keypad_disable <= 1'b1;
						end
					end
					ST_OFF_TONE:
					begin
						if (!tone_s)
						begin
							state_reg <= ST_OFF_ACK;
							ack_start <= 1'b1;
							ack_digit <= ctrl_reg[`CID_CTRL_ADSI] ? `CID_ACK_DTMF_A
							                                      : `CID_ACK_DTMF_D;
						end
					end
					ST_OFF_ACK:
						state_reg <= ST_OFF_ACK_WAIT;
					ST_OFF_ACK_WAIT:
					begin
						if (ack_done)
						begin
							state_reg    <= ST_OFF_WAIT_CD;
							demod_enable <= 1'b1;
						end
					end
					ST_OFF_WAIT_CD:
					begin
						if (!cd_n_s)
							state_reg <= ST_OFF_DATA;
						else if (timer_hit)
						begin
							state_reg      <= ST_IDLE;
							power_down_in  <= 1'b1;
							demod_enable   <= 1'b0;
							handset_mute   <= 1'b0;
							keypad_disable <= 1'b0;
						end
					end
					ST_OFF_DATA:
					begin
						if (cd_n_s)
						begin
							state_reg      <= ST_IDLE;
							power_down_in  <= 1'b1;
							demod_enable   <= 1'b0;
							handset_mute   <= 1'b0;
							keypad_disable <= 1'b0;
						end
					end
					default:
					begin
						state_reg     <= ST_IDLE;
						power_down_in <= 1'b1;
						demod_enable  <= 1'b0;
					end
				endcase
			end
		end
	end

	sequence s_ack_finished;
		state_reg == ST_OFF_ACK_WAIT && ack_done && ctrl_reg[`CID_CTRL_ENABLE] && !abort_pulse;
	endsequence
	sequence s_demod_up_waiting;
		demod_enable && state_reg == ST_OFF_WAIT_CD;
	endsequence

	property p_idle_quiet;
		@(posedge pclk) disable iff (!presetn)
		state_reg == ST_IDLE && $past(state_reg) == ST_IDLE |-> power_down_in && !demod_enable;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle not powered down");

	property p_demod_after_ack;
		@(posedge pclk) disable iff (!presetn)
		s_ack_finished |=> s_demod_up_waiting;
	endproperty
	a_demod_after_ack: assert property (p_demod_after_ack) else $error("demod late");

	property p_no_demod_before_ack;
		@(posedge pclk) disable iff (!presetn)
		state_reg inside {ST_OFF_LISTEN, ST_OFF_TONE, ST_OFF_ACK, ST_OFF_ACK_WAIT}
			|-> !demod_enable;
	endproperty
	a_no_demod_before_ack: assert property (p_no_demod_before_ack) else $error("early demod");

	property p_off_cd_end;
		@(posedge pclk) disable iff (!presetn)
		state_reg == ST_OFF_DATA && cd_n_s && ctrl_reg[`CID_CTRL_ENABLE] && !abort_pulse
			|=> !demod_enable && power_down_in && state_reg == ST_IDLE;
	endproperty
	a_off_cd_end: assert property (p_off_cd_end) else $error("off-hook end not handled");

	property p_onh_cd_end;
		@(posedge pclk) disable iff (!presetn)
		state_reg == ST_ONH_DATA && cd_n_s |=> power_down_in;
	endproperty
	a_onh_cd_end: assert property (p_onh_cd_end) else $error("no power-down after carrier");

	property p_cd_timeout;
		@(posedge pclk) disable iff (!presetn)
		state_reg == ST_ONH_WAIT_CD && cd_n_s && timer_hit
			|=> state_reg == ST_IDLE && int_status_reg[`CID_INT_CD_TO];
	endproperty
	a_cd_timeout: assert property (p_cd_timeout) else $error("carrier timeout missed");

	property p_ack_digit;
		@(posedge pclk) disable iff (!presetn)
		ack_start |-> ack_digit == ($past(ctrl_reg[`CID_CTRL_ADSI]) ? `CID_ACK_DTMF_A
		                                                            : `CID_ACK_DTMF_D);
	endproperty
	a_ack_digit: assert property (p_ack_digit) else $error("wrong ack digit");

	property p_no_fsk_unmute;
		@(posedge pclk) disable iff (!presetn)
		state_reg == ST_OFF_WAIT_CD && cd_n_s && timer_hit
			|=> !handset_mute && !keypad_disable ##1 !handset_mute;
	endproperty
	a_no_fsk_unmute: assert property (p_no_fsk_unmute) else $error("handset left muted");

	property p_ring_pd;
		@(posedge pclk) disable iff (!presetn)
		state_reg == ST_RING && $past(state_reg) == ST_RING && ctrl_reg[`CID_CTRL_PD_RING]
			&& $past(ctrl_reg[`CID_CTRL_PD_RING]) |-> power_down_in;
	endproperty
	a_ring_pd: assert property (p_ring_pd) else $error("powered up during ring");

	property p_sync_depth;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn, 2) |-> cd_n_s == $past(carrier_present_n, 2);
	endproperty
	a_sync_depth: assert property (p_sync_depth) else $error("carrier sync depth wrong");
endmodule
`default_nettype wire

// ---- bench/cid_rx_model.sv ----
// Behavioural caller-identity receiver seen from its control pins.
// Assumes the bench drives tone_line and fsk_line as the line content.
`timescale 1ns/1ps
`default_nettype none
module cid_rx_model #(
	parameter int GUARD_CYC = 6
) (
	input  wire logic pclk,              // System clock
	input  wire logic presetn,           // Async reset, active low
	input  wire logic power_down_in,     // High: receiver asleep
	input  wire logic demod_enable,      // High: demodulator on
	input  wire logic ring_active,       // Ringing on the line
	input  wire logic tone_line,         // Alert tone on the line
	input  wire logic fsk_line,          // FSK carrier on the line
	output logic      carrier_present_n, // Carrier, active low
	output logic      tone_detect_flag   // Tone present
);
	int cnt;
	// Flag follows the line only after a full guard period of agreement
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 0;
			tone_detect_flag <= 1'b0;
		end
		else if (power_down_in)
		begin
			// An asleep receiver reports no tone and forgets any partial guard
			cnt <= 0;
			tone_detect_flag <= 1'b0;
		end
		else if (tone_line == tone_detect_flag)
			cnt <= 0;
		else if (cnt == GUARD_CYC - 1)
		begin
			cnt <= 0;
			tone_detect_flag <= tone_line;
		end
		else
			cnt <= cnt + 1;
	end
	// Ringing never shows as carrier; carrier ends with the FSK signal
	assign carrier_present_n = !(fsk_line && !power_down_in && demod_enable
		&& !ring_active);
endmodule
`default_nettype wire

// ---- bench/tb_caller_id_host_sequencing.sv ----
// Self-checking bench for the caller-identity sequencer over APB.
// Assumes cid_rx_model as receiver; the bench acts as DTMF sender and line.
`timescale 1ns/1ps
`default_nettype none
`include "cid_host_params.svh"
module tb_caller_id_host_sequencing
	import cid_host_pkg::*;
;
	localparam int CDW = 50;
	localparam int NFW = 40;
	localparam int GRD = 6;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic ring_active, off_hook, carrier_present_n, tone_detect_flag;
	logic power_down_in, demod_enable, cas_detect_enable, ack_start, ack_done;
	logic handset_mute, keypad_disable, tone_line, fsk_line, err;
	logic [3:0] ack_digit;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;

	cid_host_ctrl #(.CD_WAIT_CYC(CDW), .NO_FSK_CYC(NFW)) DUT (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .ring_active(ring_active),
		.off_hook(off_hook), .carrier_present_n(carrier_present_n),
		.tone_detect_flag(tone_detect_flag), .power_down_in(power_down_in),
		.demod_enable(demod_enable), .cas_detect_enable(cas_detect_enable),
		.ack_start(ack_start), .ack_digit(ack_digit), .ack_done(ack_done),
		.handset_mute(handset_mute), .keypad_disable(keypad_disable));
	cid_rx_model #(.GUARD_CYC(GRD)) rx (.pclk(pclk), .presetn(presetn),
		.power_down_in(power_down_in), .demod_enable(demod_enable),
		.ring_active(ring_active), .tone_line(tone_line), .fsk_line(fsk_line),
		.carrier_present_n(carrier_present_n), .tone_detect_flag(tone_detect_flag));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic stop_test();
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// The run is a few hundred cycles; anything longer is a hang
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 8000)
		begin
			miscompares = miscompares + 1;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			miscompares = miscompares + 1;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Request is held until pready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge so a following call never re-drives psel in this step
		@(posedge pclk);
	endtask

	task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask

	task automatic t_reset();
		chk("pd", 32'h1, power_down_in);
		chk("digit", 32'hd, ack_digit);
		rdchk("ctrl", `CID_CTRL_OFS, 32'h11);
		rdchk("mask", `CID_INT_MASK_OFS, 32'h0);
		rdchk("int", `CID_INT_STATUS_OFS, 32'h0);
		apb(1'b1, `CID_STATUS_OFS, 32'hffff_ffff);
		rdchk("status", `CID_STATUS_OFS, 32'h50);
		rdchk("unmapped", 12'h010, 32'h0);
		chk("slverr", 32'h1, err);
	endtask

	task automatic t_onhook(input logic pdr, input logic dmo);
		apb(1'b1, `CID_CTRL_OFS, {27'h0, 1'b1, pdr, dmo, 1'b0, 1'b1});
		apb(1'b1, `CID_INT_MASK_OFS, 32'hf);
		ring_active <= 1'b1;
		fsk_line <= 1'b1;
		cyc(6);
		chk("pd ring", {31'h0, pdr}, power_down_in);
		chk("demod ring", {31'h0, dmo}, demod_enable);
		// Carrier on the line during ringing must not move the sequencer on
		rdchk("state ring", `CID_STATUS_OFS, {24'h0, dmo, pdr, 6'h11});
		ring_active <= 1'b0;
		cyc(6);
		chk("pd on", 32'h0, power_down_in);
		chk("demod on", 32'h1, demod_enable);
		rdchk("state data", `CID_STATUS_OFS, 32'h83);
		fsk_line <= 1'b0;
		cyc(5);
		chk("pd end", 32'h1, power_down_in);
		chk("demod end", 32'h0, demod_enable);
		chk("irq", 32'h1, irq);
		rdchk("int", `CID_INT_STATUS_OFS, 32'h1);
		apb(1'b1, `CID_INT_STATUS_OFS, 32'h1);
		cyc(2);
		chk("irq clr", 32'h0, irq);
	endtask

	task automatic t_timeout();
		apb(1'b1, `CID_INT_MASK_OFS, 32'h0);
		ring_active <= 1'b1;
		cyc(4);
		ring_active <= 1'b0;
		cyc(CDW + 1);
		chk("pd wait", 32'h0, power_down_in);
		cyc(1);
		chk("pd timeout", 32'h1, power_down_in);
		rdchk("int to", `CID_INT_STATUS_OFS, 32'h2);
		chk("irq masked", 32'h0, irq);
		apb(1'b1, `CID_INT_STATUS_OFS, 32'h2);
	endtask

	task automatic t_offhook(input logic adsi, input logic data);
		apb(1'b1, `CID_CTRL_OFS, {30'h4, adsi, 1'b1});
		off_hook <= 1'b1;
		cyc(4);
		tone_line <= 1'b1;
		while (tone_detect_flag !== 1'b1)
			cyc(1);
		cyc(1);
		chk("mute early", 32'h0, handset_mute);
		cyc(3);
		chk("keypad", 32'h1, keypad_disable);
		tone_line <= 1'b0;
		while (ack_start !== 1'b1)
			cyc(1);
		chk("digit", adsi ? 32'ha : 32'hd, ack_digit);
		cyc(5);
		chk("demod pre ack", 32'h0, demod_enable);
		ack_done <= 1'b1;
		cyc(1);
		ack_done <= 1'b0;
		cyc(3);
		chk("demod post ack", 32'h1, demod_enable);
		if (data)
		begin
			fsk_line <= 1'b1;
			cyc(6);
			fsk_line <= 1'b0;
			off_hook <= 1'b0;
			cyc(5);
			chk("demod off", 32'h0, demod_enable);
			chk("pd off", 32'h1, power_down_in);
			chk("unmute", 32'h0, handset_mute);
			rdchk("int done", `CID_INT_STATUS_OFS, 32'h5);
		end
		else
		begin
			cyc(NFW + 6);
			off_hook <= 1'b0;
			chk("unmute", 32'h0, handset_mute);
			chk("keypad on", 32'h0, keypad_disable);
			rdchk("int nofsk", `CID_INT_STATUS_OFS, 32'hc);
		end
		apb(1'b1, `CID_INT_STATUS_OFS, 32'hf);
		rdchk("int clr", `CID_INT_STATUS_OFS, 32'h0);
	endtask

	task automatic t_cas_off();
		apb(1'b1, `CID_CTRL_OFS, 32'h1);
		cyc(3);
		chk("cas off", 32'h0, cas_detect_enable);
		off_hook <= 1'b1;
		tone_line <= 1'b1;
		cyc(GRD + 6);
		chk("pd cas off", 32'h1, power_down_in);
		chk("mute cas off", 32'h0, handset_mute);
		off_hook <= 1'b0;
		tone_line <= 1'b0;
		apb(1'b1, `CID_CTRL_OFS, 32'h11);
		cyc(3);
		chk("cas on", 32'h1, cas_detect_enable);
	endtask

	task automatic t_abort();
		apb(1'b1, `CID_CTRL_OFS, 32'h11);
		off_hook <= 1'b1;
		cyc(3);
		chk("pd listen", 32'h0, power_down_in);
		apb(1'b1, `CID_CTRL_OFS, 32'h31);
		off_hook <= 1'b0;
		cyc(1);
		chk("pd abort", 32'h1, power_down_in);
		rdchk("abort clr", `CID_CTRL_OFS, 32'h11);
	endtask

	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, ring_active, off_hook, ack_done} = 6'h0;
		{tone_line, fsk_line} = 2'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		cyc(8);
		presetn <= 1'b1;
		cyc(2);
		t_reset();
		t_onhook(1'b1, 1'b0);
		t_onhook(1'b0, 1'b1);
		t_timeout();
		apb(1'b1, `CID_INT_MASK_OFS, 32'hf);
		t_offhook(1'b0, 1'b1);
		t_offhook(1'b1, 1'b1);
		t_offhook(1'b0, 1'b0);
		t_cas_off();
		t_abort();
		stop_test();
	end
endmodule
`default_nettype wire
